// file: design/sac_pkg.sv
package sac_pkg;
   // register map (byte addresses on the avalon word bus: offset times four)
   localparam logic [7:0] RESULT_INDEX     = 8'h1d;
   localparam logic [7:0] STATUS_INDEX     = 8'h1e;
   localparam logic [9:0] RESULT_ADDR      = {RESULT_INDEX, 2'b00};
   localparam logic [9:0] STATUS_ADDR      = {STATUS_INDEX, 2'b00};
   // status/control fields
   localparam int         COMPLETE_BIT     = 7;
   localparam int         RC_SEL_BIT       = 6;
   localparam int         POWER_BIT        = 5;
   localparam int         CHAN_MSB         = 2;
   localparam logic [7:0] STATUS_RESET     = 8'h00;
   // conversion timing
   localparam int         CONV_CYCLES      = 32;
   localparam int         SAMPLE_CYCLE     = 0;
   localparam int         FIRST_BIT_CYCLE  = 8;
   localparam int         RESULT_BITS      = 8;
   // channel codes
   localparam logic [2:0] CHAN_PIN_ZERO    = 3'h0;
   localparam logic [2:0] CHAN_PIN_ONE     = 3'h1;
   localparam logic [2:0] CHAN_HIGH_REF    = 3'h4;
   localparam logic [2:0] CHAN_MID_REF     = 3'h5;
   localparam logic [2:0] CHAN_LOW_REF     = 3'h6;
   localparam logic [2:0] CHAN_TEST        = 3'h7;
   localparam logic [7:0] FULL_SCALE       = 8'hff;
   localparam logic [7:0] ZERO_SCALE       = 8'h00;
   localparam logic [7:0] MID_SCALE        = 8'h80;

   typedef enum logic [1:0] {
      SAC_IDLE   = 2'b00,
      SAC_SAMPLE = 2'b01,
      SAC_CONV   = 2'b10
   } sac_state_e;

   typedef struct packed {
      logic       complete;
      logic       rc_sel;
      logic       power;
      logic [2:0] chan;
   } sac_ctrl_s;
endpackage : sac_pkg

// file: design/sac_clock_pick.sv
`timescale 1ns/1ns
`default_nettype none
// chooses the conversion tick: every bus clock or the synchronised rc tick
module sac_clock_pick (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic rc_sel,
   input  wire logic rc_tick,
   output logic      conv_tick
);
   logic rc_meta;
   logic rc_sync;
   logic rc_prev;

   // rc pulses come from an unrelated oscillator, so two stages first
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rc_meta <= 1'b0;
         rc_sync <= 1'b0;
         rc_prev <= 1'b0;
      end else begin
         rc_meta <= rc_tick;
         rc_sync <= rc_meta;
         rc_prev <= rc_sync;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_tick <= 1'b0;
      end else begin
         conv_tick <= rc_sel ? (rc_sync & ~rc_prev) : 1'b1;
      end
   end
endmodule : sac_clock_pick
`default_nettype wire

// file: design/sac_control.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - eight-bit successive approximation on selected input
// - input sampled once at conversion start
// - each conversion takes exactly 32 clocks
// - at high reference gives ff, low 00
// - rc select clocks converter from rc tick
// - complete flag set when result stored
// - flag cleared: control write, result read, power-off
// - repeat conversions every 32 clocks continuously
// - new result overwrites unread old one
// - channels 0,1 pins; 4,5,6 references; 7 test
// - channels 2,3,7 give undefined result
// - shared pin reads zero when input direction, powered and selected as channel
// - shared pin output direction reads latch
// - wait mode keeps converter running
// - stop mode aborts conversion, ends activity
// - status layout: flag7 rc6 power5 channel2:0
// - result register read-only, holds latest
module sac_control (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // avalon-mm slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // analog side
   input  wire logic        rc_tick,
   input  wire logic        compare_high,
   output logic [7:0]       dac_code,
   output logic [2:0]       mux_select,
   output logic             sample_hold,
   output logic             analog_power,
   output logic             rc_osc_enable,
   // low-power modes
   input  wire logic        stop_mode,
   input  wire logic        wait_mode,
   // shared port pins four and five
   input  wire logic [1:0]  port_pin_in,
   input  wire logic [1:0]  port_dir_out,
   input  wire logic [1:0]  port_latch,
   output logic [1:0]       port_read_value
);
   ////////////////////////////////////////////////////////////////////////////
   sac_pkg::sac_ctrl_s   ctrl;
   sac_pkg::sac_state_e  state;
   logic [4:0]           cycle;
   logic [7:0]           sar;
   logic [7:0]           result;
   logic                 conv_tick;
   logic                 acc_done;
   logic                 hit_status;
   logic                 hit_result;
   logic                 status_wr;
   logic                 result_rd;
   logic                 finish;
   logic [2:0]           bit_idx;
   logic                 wait_unused;
   logic [5:0]           since_start;

   // wait mode changes nothing here
   assign wait_unused = wait_mode;

   function automatic logic shared_chan(input logic [2:0] ch, input logic which);
      shared_chan = (ch == (which ? sac_pkg::CHAN_PIN_ONE : sac_pkg::CHAN_PIN_ZERO));
   endfunction : shared_chan

   sac_clock_pick u_pick (
      .clk       (clk),
      .reset_n   (reset_n),
      .rc_sel    (ctrl.rc_sel),
      .rc_tick   (rc_tick),
      .conv_tick (conv_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus: one wait state, answer on second edge of the request
   assign hit_status = (avs_address == sac_pkg::STATUS_ADDR);
   assign hit_result = (avs_address == sac_pkg::RESULT_ADDR);
   assign status_wr  = avs_write & acc_done & hit_status & avs_byteenable[0];
   assign result_rd  = avs_read & acc_done & hit_result;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_done <= 1'b0;
      end else begin
         acc_done <= (avs_read | avs_write) & ~acc_done;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & ~acc_done & avs_waitrequest);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~acc_done) begin
         if (hit_status) begin
            avs_readdata <= {24'h0, ctrl.complete, ctrl.rc_sel, ctrl.power, 2'b00, ctrl.chan};
         end else if (hit_result) begin
            avs_readdata <= {24'h0, result};
         end else begin
            avs_readdata <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl.rc_sel <= 1'b0;
         ctrl.power  <= 1'b0;
         ctrl.chan   <= 3'h0;
      end else if (status_wr) begin
         ctrl.rc_sel <= avs_writedata[sac_pkg::RC_SEL_BIT];
         ctrl.power  <= avs_writedata[sac_pkg::POWER_BIT];
         ctrl.chan   <= avs_writedata[sac_pkg::CHAN_MSB:0];
      end
   end

   // set wins over a result-read clear; a control write, power-off and stop clear it regardless
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl.complete <= 1'b0;
      end else if (!ctrl.power || stop_mode) begin
         ctrl.complete <= 1'b0;
      end else if (finish && !status_wr) begin
         ctrl.complete <= 1'b1;
      end else if (status_wr || result_rd) begin
         ctrl.complete <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer: cycle 0 samples, cycles 8..15 decide one bit each
   assign bit_idx = 3'(sac_pkg::RESULT_BITS - 1) - 3'(cycle - 5'(sac_pkg::FIRST_BIT_CYCLE));
   assign finish  = (state == sac_pkg::SAC_CONV) && conv_tick
                    && (cycle == 5'(sac_pkg::CONV_CYCLES - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= sac_pkg::SAC_IDLE;
         cycle <= 5'h0;
      end else if (stop_mode) begin
         state <= sac_pkg::SAC_IDLE;
         cycle <= 5'h0;
      end else if (status_wr) begin
         // the written power bit decides, so a power-on write starts at once
         state <= avs_writedata[sac_pkg::POWER_BIT] ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
         cycle <= 5'h0;
      end else if (!ctrl.power) begin
         state <= sac_pkg::SAC_IDLE;
         cycle <= 5'h0;
      end else if (conv_tick) begin
         unique case (state)
            sac_pkg::SAC_IDLE: begin
               state <= sac_pkg::SAC_SAMPLE;
               cycle <= 5'h0;
            end
            sac_pkg::SAC_SAMPLE: begin
               state <= sac_pkg::SAC_CONV;
               cycle <= 5'h1;
            end
            sac_pkg::SAC_CONV: begin
               cycle <= cycle + 5'h1;
               if (finish) begin
                  state <= sac_pkg::SAC_SAMPLE;
               end
            end
            default: state <= sac_pkg::SAC_IDLE;
         endcase
      end
   end

   // hold is asserted in the clock after each sample-state clock only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_hold <= 1'b0;
      end else begin
         sample_hold <= (state == sac_pkg::SAC_SAMPLE) && ctrl.power && !stop_mode;
      end
   end

   // trial code lives in the dac register itself: a copy one clock behind
   // would hand the comparator a stale code when ticks come every clock
   assign sar = dac_code;

   // decision per bit; full scale input keeps every bit set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dac_code <= 8'h00;
      end else if (state == sac_pkg::SAC_SAMPLE) begin
         dac_code <= sac_pkg::MID_SCALE;
      end else if (state == sac_pkg::SAC_CONV && conv_tick && cycle >= 5'(sac_pkg::FIRST_BIT_CYCLE)
                   && cycle < 5'(sac_pkg::FIRST_BIT_CYCLE + sac_pkg::RESULT_BITS)) begin
         dac_code[bit_idx] <= compare_high;
         if (bit_idx != 3'h0) begin
            dac_code[bit_idx - 3'h1] <= 1'b1;
         end
      end
   end

   // no reset: content is undefined until first conversion
   always_ff @(posedge clk) begin
      if (finish) begin
         result <= sar;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls; reserved codes pass through, result meaningless
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mux_select    <= 3'h0;
         analog_power  <= 1'b0;
         rc_osc_enable <= 1'b0;
      end else begin
         mux_select    <= ctrl.chan;
         analog_power  <= ctrl.power && !stop_mode;
         rc_osc_enable <= ctrl.rc_sel && !stop_mode;
      end
   end

   // port read path for the two shared pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_read_value <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (port_dir_out[i]) begin
               port_read_value[i] <= port_latch[i];
            end else if (ctrl.power && shared_chan(ctrl.chan, i[0])) begin
               port_read_value[i] <= 1'b0;
            end else begin
               port_read_value[i] <= port_pin_in[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_conv_length: assert property (@(posedge clk) disable iff (!reset_n)
      (state == sac_pkg::SAC_SAMPLE && conv_tick && !ctrl.rc_sel && ctrl.power && !status_wr && !stop_mode)
      ##1 (ctrl.power && !stop_mode && !status_wr && !ctrl.rc_sel) [*8]
      |-> (state == sac_pkg::SAC_CONV))
      else $error("conversion left early");
   a_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
      (finish && ctrl.power && !stop_mode && !status_wr) |=> ctrl.complete)
      else $error("complete flag not set at finish");
   a_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
      ((result_rd || status_wr) && !finish) |=> !ctrl.complete)
      else $error("complete flag not cleared");
   a_result_update: assert property (@(posedge clk) disable iff (!reset_n)
      finish |=> (result == $past(sar)))
      else $error("result not overwritten");
   a_stop_abort: assert property (@(posedge clk) disable iff (!reset_n)
      stop_mode |=> (state == sac_pkg::SAC_IDLE && !analog_power))
      else $error("stop did not abort");
   a_restart_write: assert property (@(posedge clk) disable iff (!reset_n)
      (status_wr && avs_writedata[sac_pkg::POWER_BIT] && !stop_mode) |=> (state == sac_pkg::SAC_SAMPLE && cycle == 5'h0))
      else $error("write did not restart");
   a_pin_zero: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl.power && ctrl.chan == sac_pkg::CHAN_PIN_ZERO && !port_dir_out[0]) |=> !port_read_value[0])
      else $error("shared pin read not zero");
   a_pin_latch: assert property (@(posedge clk) disable iff (!reset_n)
      port_dir_out[1] |=> (port_read_value[1] == $past(port_latch[1])))
      else $error("latch value not returned");
   a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
      (avs_read && !acc_done && hit_status) |=> (avs_readdata[4:3] == 2'b00 && avs_readdata[31:8] == 24'h0))
      else $error("reserved status bits not zero");

   // clocks since a bus-clock start; a start that leaves rc mode is skipped,
   // since the tick picker needs one clock to follow the new select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         since_start <= 6'h0;
      end else if (status_wr && !stop_mode) begin
         since_start <= (avs_writedata[sac_pkg::POWER_BIT] && !avs_writedata[sac_pkg::RC_SEL_BIT]
                         && !ctrl.rc_sel) ? 6'h1 : 6'h0;
      end else if (stop_mode || since_start == 6'(sac_pkg::CONV_CYCLES)) begin
         since_start <= 6'h0;
      end else if (since_start != 6'h0) begin
         since_start <= since_start + 6'h1;
      end
   end

   a_conv_finish: assert property (@(posedge clk) disable iff (!reset_n)
      (since_start == 6'(sac_pkg::CONV_CYCLES)) |-> finish)
      else $error("conversion did not finish after 32 clocks");
   a_conv_early: assert property (@(posedge clk) disable iff (!reset_n)
      (since_start != 6'h0 && since_start < 6'(sac_pkg::CONV_CYCLES)) |-> !finish)
      else $error("conversion finished early");
   a_bus_wait: assert property (@(posedge clk) disable iff (!reset_n)
      ((avs_read || avs_write) && !acc_done && avs_waitrequest) |=> !avs_waitrequest)
      else $error("access not answered after one wait state");
   a_wait_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_power_clear: assert property (@(posedge clk) disable iff (!reset_n)
      !ctrl.power |=> !ctrl.complete)
      else $error("complete flag set while powered off");
   a_mux_follow: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> (mux_select == $past(ctrl.chan)))
      else $error("mux select does not follow channel");
   a_hold_conv: assert property (@(posedge clk) disable iff (!reset_n)
      (state == sac_pkg::SAC_CONV && $past(state) == sac_pkg::SAC_CONV) |-> !sample_hold)
      else $error("input resampled during conversion");
   a_hold_off: assert property (@(posedge clk) disable iff (!reset_n)
      !ctrl.power |=> !sample_hold)
      else $error("sample hold while powered off");
   a_port_normal: assert property (@(posedge clk) disable iff (!reset_n)
      (!ctrl.power && !port_dir_out[0]) |=> (port_read_value[0] == $past(port_pin_in[0])))
      else $error("port pin not read normally");
   a_rc_single: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl.rc_sel && $past(ctrl.rc_sel) && conv_tick) |=> !conv_tick)
      else $error("rc tick longer than one clock");
   a_rc_enable: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl.rc_sel && !stop_mode) |=> rc_osc_enable)
      else $error("rc oscillator not enabled");
   a_stop_rc: assert property (@(posedge clk) disable iff (!reset_n)
      stop_mode |=> !rc_osc_enable)
      else $error("rc oscillator running in stop");
endmodule : sac_control
`default_nettype wire

// file: verification/sac_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module sac_analog_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] pin_four_level,
   input  wire logic [7:0] pin_five_level,
   input  wire logic [7:0] dac_code,
   input  wire logic [2:0] mux_select,
   input  wire logic       sample_hold,
   input  wire logic       rc_osc_enable,
   output logic            compare_high,
   output var logic        rc_tick
);
   logic [7:0] level;
   logic [7:0] held;
   always_comb begin
      case (mux_select)
         sac_pkg::CHAN_PIN_ZERO: level = pin_four_level;
         sac_pkg::CHAN_PIN_ONE:  level = pin_five_level;
         sac_pkg::CHAN_HIGH_REF: level = sac_pkg::FULL_SCALE;
         sac_pkg::CHAN_MID_REF:  level = sac_pkg::MID_SCALE;
         sac_pkg::CHAN_LOW_REF:  level = sac_pkg::ZERO_SCALE;
         default:                level = 8'h5a;
      endcase
   end
   // later pin changes must not leak into a running conversion
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) held <= 8'h00;
      else if (sample_hold) held <= level;
   end
   assign compare_high = (held >= dac_code);
   // rc oscillator near 1.5 MHz, unrelated to clk, still while disabled;
   // its toggles never land on a rising clk edge
   initial begin
      rc_tick = 1'b0;
      forever begin
         #330;
         rc_tick = rc_osc_enable ? ~rc_tick : 1'b0;
      end
   end
endmodule : sac_analog_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   typedef struct packed {
      logic [2:0] ch;
      logic [7:0] l4;
      logic [7:0] l5;
      logic [7:0] res;
      logic [1:0] port;
   } sac_row_s;
   logic        clk, reset_n, read, write, rc_tick, compare_high, sample_hold;
   logic        analog_power, rc_osc_enable, stop_mode, wait_mode, waitrequest;
   logic [9:0]  address;
   logic [31:0] writedata, readdata;
   logic [7:0]  dac_code, lvl4, lvl5, q;
   logic [2:0]  mux_select;
   logic [1:0]  port_read_value, pin_in, dir_out, latch;
   localparam int SETTLE_CYCLES = 10; // stands in for power and rc settle times
   int          err_total, cmp_count, n;
   sac_row_s    rows [5] = '{{3'h0, 8'h3c, 8'hc3, 8'h3c, 2'h2}, {3'h1, 8'h3c, 8'ha5, 8'ha5, 2'h1},
                             {3'h4, 8'h00, 8'h00, 8'hff, 2'h3}, {3'h5, 8'h00, 8'h00, 8'h80, 2'h3},
                             {3'h6, 8'hff, 8'hff, 8'h00, 2'h3}};
   sac_control u_sac_control (.clk(clk), .reset_n(reset_n), .avs_address(address), .avs_read(read),
      .avs_write(write), .avs_writedata(writedata), .avs_byteenable(4'hf), .avs_readdata(readdata),
      .avs_waitrequest(waitrequest), .rc_tick(rc_tick), .compare_high(compare_high), .dac_code(dac_code),
      .mux_select(mux_select), .sample_hold(sample_hold), .analog_power(analog_power),
      .rc_osc_enable(rc_osc_enable), .stop_mode(stop_mode), .wait_mode(wait_mode), .port_pin_in(pin_in),
      .port_dir_out(dir_out), .port_latch(latch), .port_read_value(port_read_value));
   sac_analog_model u_sac_analog_model (.clk(clk), .reset_n(reset_n), .pin_four_level(lvl4),
      .pin_five_level(lvl5), .dac_code(dac_code), .mux_select(mux_select), .sample_hold(sample_hold),
      .rc_osc_enable(rc_osc_enable), .compare_high(compare_high), .rc_tick(rc_tick));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check8
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
      int k;
      k = 0;
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         err_total++;
         end_sim();
      end
      r = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wait_done(input int lim);
      logic [7:0] s;
      int         k;
      k = 0;
      do begin
         bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, s);
         k++;
      end while (s[sac_pkg::COMPLETE_BIT] !== 1'b1 && k < lim);
      if (k >= lim) begin
         err_total++;
         end_sim();
      end
   endtask : wait_done
   task automatic wait_sh(input logic v, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (sample_hold !== v && k < 100);
      if (k >= 100) begin
         err_total++;
         end_sim();
      end
   endtask : wait_sh
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      int m;
      {reset_n, read, write, stop_mode, address, writedata, lvl4, lvl5, dir_out, latch} = '0;
      pin_in = 2'h3;
      wait_mode = 1'b1;
      err_total = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("status reset", sac_pkg::STATUS_RESET, q);
      foreach (rows[i]) begin
         lvl4 <= rows[i].l4;
         lvl5 <= rows[i].l5;
         bus(1'b1, sac_pkg::STATUS_ADDR, 8'h20 | {5'h0, rows[i].ch}, q);
         wait_done(40);
         check8("port", {6'h0, rows[i].port}, {6'h0, port_read_value});
         bus(1'b0, sac_pkg::RESULT_ADDR, 8'h00, q);
         check8("result", rows[i].res, q);
         bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
         check8("status", 8'h20 | {5'h0, rows[i].ch}, q);
      end
      lvl4 <= 8'h40;
      bus(1'b1, sac_pkg::STATUS_ADDR, 8'h20, q);
      wait_sh(1'b1, n);
      wait_sh(1'b0, n);
      lvl4 <= 8'hc0;
      wait_done(40);
      bus(1'b0, sac_pkg::RESULT_ADDR, 8'h00, q);
      check8("sampled", 8'h40, q);
      wait_sh(1'b1, n);
      wait_sh(1'b0, n);
      wait_sh(1'b1, m);
      check8("period", 8'd32, 8'(n + m));
      repeat (70) @(posedge clk);
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("repeat flag", 8'ha0, q);
      repeat (40) @(posedge clk);
      bus(1'b0, sac_pkg::RESULT_ADDR, 8'h00, q);
      check8("overwrite", 8'hc0, q);
      wait_done(40);
      bus(1'b1, sac_pkg::STATUS_ADDR, 8'h39, q);
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("rewrite", 8'h21, q);
      dir_out <= 2'h2;
      latch <= 2'h2;
      repeat (3) @(posedge clk);
      check8("pin latch", 8'h03, {6'h0, port_read_value});
      dir_out <= 2'h0;
      // stop arrives mid conversion
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk);
      check8("stop power", 8'h00, {7'h0, analog_power});
      repeat (40) @(posedge clk);
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("stop flag", 8'h00, {7'h0, q[sac_pkg::COMPLETE_BIT]});
      stop_mode <= 1'b0;
      lvl5 <= 8'h66;
      wait_done(40);
      bus(1'b1, sac_pkg::RESULT_ADDR, 8'h99, q);
      bus(1'b0, sac_pkg::RESULT_ADDR, 8'h00, q);
      check8("result ro", 8'h66, q);
      bus(1'b0, 10'h000, 8'h00, q);
      check8("unmapped", 8'h00, q);
      bus(1'b1, sac_pkg::STATUS_ADDR, 8'h64, q);
      repeat (2) @(posedge clk);
      check8("rc enable", 8'h01, {7'h0, rc_osc_enable});
      repeat (SETTLE_CYCLES) @(posedge clk);
      wait_done(400);
      bus(1'b0, sac_pkg::RESULT_ADDR, 8'h00, q);
      check8("rc result", 8'hff, q);
      // reset again while rc conversions run
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      check8("reset wait", 8'h01, {7'h0, waitrequest});
      reset_n <= 1'b1;
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("reset status", sac_pkg::STATUS_RESET, q);
      check8("reset power", 8'h00, {6'h0, analog_power, rc_osc_enable});
      bus(1'b1, sac_pkg::STATUS_ADDR, 8'h27, q);
      repeat (3) @(posedge clk);
      check8("pin ch7", 8'h03, {6'h0, port_read_value});
      wait_done(40);
      bus(1'b1, sac_pkg::STATUS_ADDR, 8'h00, q);
      pin_in <= 2'h1;
      repeat (3) @(posedge clk);
      bus(1'b0, sac_pkg::STATUS_ADDR, 8'h00, q);
      check8("off status", 8'h00, q);
      check8("off", 8'h00, {6'h0, analog_power, rc_osc_enable});
      check8("pin free", 8'h01, {6'h0, port_read_value});
      end_sim();
   end
endmodule : tb
`default_nettype wire
